/* File: hdl/sup_pkg.sv */
// constants shared by the supply controller register bank
package sup_pkg;
  // window inside the system controller space, byte addresses
  localparam logic [7:0] SUP_BASE = 8'h10;
  localparam logic [7:0] SUP_LAST = 8'h2C;
  // local register offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_MON = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h14;
  // command register fields
  localparam int PWD_MSB = 31;
  localparam int PWD_LSB = 24;
  localparam logic [7:0] PWD_VALUE = 8'hA5;
  localparam int XTAL_SEL_BIT = 3;
  localparam int ZERO_BIT = 2;
  // status register field
  localparam int OSC_SEL_BIT = 7;
  // reset values and the monitor writable mask
  localparam logic [31:0] MON_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_RESET = 32'h00E0_5A00;
  localparam logic [31:0] STATE_RESET = 32'h0000_0000;
  localparam logic [31:0] MON_MASK = 32'h0000_370F;
  // crystal start-up, counted in rc oscillator periods
  localparam int XTAL_START_RC = 16;
  // crystal switch sequence
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_PINS, SEQ_XTAL_ON, SEQ_WAIT, SEQ_SWITCH, SEQ_RC_OFF, SEQ_DONE
  } sup_seq_e;
endpackage

/* File: hdl/sup_xtal_seq.sv */
// slow clock source switch sequencer
`timescale 1ns/1ps
module sup_xtal_seq #(
  parameter int START_RC = sup_pkg::XTAL_START_RC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command and rc oscillator clock pin
  input wire logic startReq,
  input wire logic rcClkPin,
  // oscillator controls
  output logic pinsToXtal,
  output logic xtalEnable,
  output logic slowClkXtal,
  output logic rcEnable
);
  sup_pkg::sup_seq_e stateQ, stateD;
  logic [15:0] cntQ, cntD;
  logic rcS1Q, rcS2Q, rcS3Q;
  logic pinsQ, pinsD, xtalQ, xtalD, selQ, selD, rcQ, rcD;
  logic rcTick;

  // two-stage sync of the rc clock, then edge detect on stage two
  always_ff @(posedge clk) begin
    if (rst) begin
      rcS1Q <= 1'b0;
      rcS2Q <= 1'b0;
      rcS3Q <= 1'b0;
    end else begin
      rcS1Q <= rcClkPin;
      rcS2Q <= rcS1Q;
      rcS3Q <= rcS2Q;
    end
  end
  assign rcTick = rcS2Q & ~rcS3Q;

  // ordered sequence: pins, enable, wait, switch, rc off
  always_comb begin
    stateD = stateQ;
    cntD = cntQ;
    pinsD = pinsQ;
    xtalD = xtalQ;
    selD = selQ;
    rcD = rcQ;
    case (stateQ)
      sup_pkg::SEQ_IDLE: if (startReq) stateD = sup_pkg::SEQ_PINS;
      sup_pkg::SEQ_PINS: begin
        pinsD = 1'b1; // [RQ9]
        stateD = sup_pkg::SEQ_XTAL_ON;
      end
      sup_pkg::SEQ_XTAL_ON: begin
        xtalD = 1'b1; // [RQ9]
        cntD = 16'h0000;
        stateD = sup_pkg::SEQ_WAIT;
      end
      sup_pkg::SEQ_WAIT: if (rcTick) begin
        if (cntQ == 16'(START_RC - 1)) stateD = sup_pkg::SEQ_SWITCH; // [RQ9]
        else cntD = cntQ + 16'h0001;
      end
      sup_pkg::SEQ_SWITCH: if (rcTick) begin
        selD = 1'b1; // switch aligned to an rc edge, no runt pulse [RQ7] [RQ9]
        stateD = sup_pkg::SEQ_RC_OFF;
      end
      sup_pkg::SEQ_RC_OFF: begin
        rcD = 1'b0; // [RQ9]
        stateD = sup_pkg::SEQ_DONE;
      end
      sup_pkg::SEQ_DONE: stateD = sup_pkg::SEQ_DONE; // only rst returns it to SEQ_IDLE
      default: stateD = sup_pkg::SEQ_IDLE;
    endcase
  end

  // sequence registers
  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ <= sup_pkg::SEQ_IDLE;
      cntQ <= 16'h0000;
      pinsQ <= 1'b0;
      xtalQ <= 1'b0;
      selQ <= 1'b0;
      rcQ <= 1'b1;
    end else begin
      stateQ <= stateD;
      cntQ <= cntD;
      pinsQ <= pinsD;
      xtalQ <= xtalD;
      selQ <= selD;
      rcQ <= rcD;
    end
  end

  assign pinsToXtal = pinsQ;
  assign xtalEnable = xtalQ;
  assign slowClkXtal = selQ;
  assign rcEnable = rcQ;

  // order checks
  xtal_after_pins_a: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    $rose(xtalQ) |-> $past(pinsQ)) else $error("crystal enabled before pins");
  switch_after_wait_a: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    $rose(selQ) |-> xtalQ && $past(stateQ) == sup_pkg::SEQ_SWITCH && $past(rcTick))
    else $error("slow clock switched out of order");
  rc_off_after_a: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    $fell(rcQ) |-> $past(selQ)) else $error("rc disabled before switch");
endmodule // sup_xtal_seq

/* File: hdl/sup_reg_bank.sv */
// supply controller register bank on classic wishbone
// Operation
// RQ1: registers occupy system controller offsets 0x10 through 0x2C.
// RQ2: command register at local 0x00, write-only, no reset value.
// RQ3: monitor mode register at local 0x04, read/write, resets to zero.
// RQ4: mode register at local 0x08, read/write, resets to 0x00E0_5A00.
// RQ5: status register at local 0x14, read-only, resets to zero.
// RQ6: command write acts only with key 0xA5; key reads as zero.
// RQ7: keyed write with bit 3 set moves slow clock to crystal.
// RQ8: software always writes bit 2 of the command word as zero.
// RQ9: sequence: pins, crystal on, rc-counted wait, clean switch, rc off.
// RQ10: reserved offsets in the window ignore writes and read zero.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module sup_reg_bank #(
  parameter int START_RC = sup_pkg::XTAL_START_RC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave, byte address in system controller space
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic wbCyc,
  input wire logic wbStb,
  output logic wbAck,
  output logic wbErr,
  // configuration seen by the monitor and regulator
  output logic [31:0] monitorMode,
  output logic [31:0] supplyMode,
  // oscillator pins and controls
  input wire logic rcClkPin,
  output logic pinsToXtal,
  output logic xtalEnable,
  output logic slowClkXtal,
  output logic rcEnable
);
  logic ackQ, ackD, errQ, errD;
  logic [31:0] datQ, datD;
  logic [31:0] monQ, monD, modeQ, modeD;
  logic [31:0] laneMask;
  logic [7:0] local_;
  logic inWin, req, wrNow, cmdHit, keyOk, startReq;

  // window decode [RQ1]
  assign inWin = (wbAdr >= sup_pkg::SUP_BASE) && (wbAdr <= sup_pkg::SUP_LAST);
  assign local_ = wbAdr - sup_pkg::SUP_BASE;
  assign req = wbCyc & wbStb;
  assign wrNow = req & wbWe & ackQ;

  // byte lane enables spread to bits
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign laneMask[gi*8 +: 8] = {8{wbSel[gi]}};
    end
  endgenerate

  // keyed command decode [RQ2] [RQ6]
  assign cmdHit = wrNow && local_ == sup_pkg::OFF_CMD;
  assign keyOk = wbSel[3] && wbDatI[sup_pkg::PWD_MSB:sup_pkg::PWD_LSB] == sup_pkg::PWD_VALUE;
  assign startReq = cmdHit & keyOk & wbSel[0] & wbDatI[sup_pkg::XTAL_SEL_BIT]; // [RQ6] [RQ7]

  // bus handshake and read data
  always_comb begin
    ackD = 1'b0;
    errD = 1'b0;
    datD = datQ;
    if (req && !ackQ && !errQ) begin
      if (inWin) begin
        ackD = 1'b1;
        case (local_)
          sup_pkg::OFF_MON: datD = monQ; // [RQ3]
          sup_pkg::OFF_MODE: datD = modeQ; // [RQ4]
          sup_pkg::OFF_STATE: begin
            datD = sup_pkg::STATE_RESET; // [RQ5]
            datD[sup_pkg::OSC_SEL_BIT] = slowClkXtal;
          end
          default: datD = 32'h0000_0000; // command and reserved read zero [RQ2] [RQ10]
        endcase
      end else begin
        errD = 1'b1;
        datD = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ackQ <= 1'b0;
      errQ <= 1'b0;
      datQ <= 32'h0000_0000;
    end else begin
      ackQ <= ackD;
      errQ <= errD;
      datQ <= datD;
    end
  end

  // writable registers; reserved offsets fall through untouched [RQ10]
  always_comb begin
    monD = monQ;
    modeD = modeQ;
    if (wrNow && local_ == sup_pkg::OFF_MON)
      monD = ((monQ & ~laneMask) | (wbDatI & laneMask)) & sup_pkg::MON_MASK; // [RQ3]
    if (wrNow && local_ == sup_pkg::OFF_MODE)
      modeD = (modeQ & ~laneMask) | (wbDatI & laneMask); // [RQ4]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      monQ <= sup_pkg::MON_RESET; // [RQ3]
      modeQ <= sup_pkg::MODE_RESET; // [RQ4]
    end else begin
      monQ <= monD;
      modeQ <= modeD;
    end
  end

  assign wbAck = ackQ;
  assign wbErr = errQ;
  assign wbDatO = datQ;
  assign monitorMode = monQ;
  assign supplyMode = modeQ;

  // crystal switch sequencer
  sup_xtal_seq #(.START_RC(START_RC)) u_seq (
    .clk(clk),
    .rst(rst),
    .startReq(startReq),
    .rcClkPin(rcClkPin),
    .pinsToXtal(pinsToXtal),
    .xtalEnable(xtalEnable),
    .slowClkXtal(slowClkXtal),
    .rcEnable(rcEnable)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ack_one_cycle_a: assert property ($rose(wbAck) |=> !wbAck) // [RQ1]
    else $error("ack held longer than one cycle");
  window_ack_a: assert property (req && !ackQ && !errQ |=> (wbAck == $past(inWin)) // [RQ1]
    && (wbErr == !$past(inWin))) else $error("wrong answer to window decode");
  cmd_reads_zero_a: assert property ($rose(wbAck) // [RQ2]
    && $past(local_ == sup_pkg::OFF_CMD && !wbWe)
    |-> wbDatO == 32'h0000_0000) else $error("command register read not zero");
  mon_write_a: assert property (wrNow && local_ == sup_pkg::OFF_MON && wbSel == 4'hF // [RQ3]
    |=> monQ == ($past(wbDatI) & sup_pkg::MON_MASK)) else $error("monitor write lost");
  mode_write_a: assert property (wrNow && local_ == sup_pkg::OFF_MODE && wbSel == 4'hF // [RQ4]
    |=> modeQ == $past(wbDatI)) else $error("mode write lost");
  status_read_a: assert property ($rose(wbAck) // [RQ5]
    && $past(local_ == sup_pkg::OFF_STATE && !wbWe)
    |-> wbDatO == {24'h000000, $past(slowClkXtal), 7'h00}) else $error("bad status read");
  bad_key_a: assert property (cmdHit && !keyOk |=> ##3 !pinsToXtal // [RQ6]
    || $past(pinsToXtal, 4)) else $error("unkeyed command started switch");
  xtal_start_a: assert property (startReq && !pinsToXtal |=> ##1 pinsToXtal ##1 xtalEnable) // [RQ7]
    else $error("keyed crystal select did not start");
  reserved_quiet_a: assert property (wrNow && local_ != sup_pkg::OFF_MON // [RQ10]
    && local_ != sup_pkg::OFF_MODE |=> $stable(monQ) && $stable(modeQ))
    else $error("reserved write changed a register");
endmodule // sup_reg_bank

/* File: test/supply_ctrl_register_bank_test.sv */
// self-checking bench for the supply controller register bank
`timescale 1ns/1ps
module supply_ctrl_register_bank_test;
  typedef struct packed {
    logic we; logic [7:0] adr; logic [31:0] dat; logic [3:0] sel;
    logic [31:0] exp; logic [31:0] msk; logic err;
  } sup_row_s;
  logic clk = 1'b0;
  logic rst, wbWe, wbCyc, wbStb, wbAck, wbErr, rcClkPin;
  logic [7:0] wbAdr;
  logic [31:0] wbDatI, wbDatO, monitorMode, supplyMode, rd;
  logic [3:0] wbSel;
  logic [1:0] rcCnt = 2'h0;
  logic pinsToXtal, xtalEnable, slowClkXtal, rcEnable, er;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  // ordinary accesses: reset values, masks, read-only, reserved, out of window
  sup_row_s rows [0:15] = '{
    '{1'b0, 8'h14, 32'h0, 4'hF, 32'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'h18, 32'h0, 4'hF, 32'h00E05A00, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'h24, 32'h0, 4'hF, 32'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'h10, 32'h0, 4'hF, 32'h0, 32'hFF000000, 1'b0},
    '{1'b1, 8'h14, 32'hFFFFFFFF, 4'hF, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h14, 32'h0, 4'hF, 32'h0000370F, 32'hFFFFFFFF, 1'b0},
    '{1'b1, 8'h18, 32'h12345678, 4'h3, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h18, 32'h0, 4'hF, 32'h00E05678, 32'hFFFFFFFF, 1'b0},
    '{1'b1, 8'h24, 32'hFFFFFFFF, 4'hF, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h24, 32'h0, 4'hF, 32'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b1, 8'h1C, 32'hFFFFFFFF, 4'hF, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h1C, 32'h0, 4'hF, 32'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'h2C, 32'h0, 4'hF, 32'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'h20, 32'h0, 4'hF, 32'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 4'hF, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h30, 32'hFFFFFFFF, 4'hF, 32'h0, 32'h0, 1'b1}
  };

  sup_reg_bank #(.START_RC(2)) uut (
    .clk(clk), .rst(rst), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbWe(wbWe),
    .wbSel(wbSel), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .wbErr(wbErr),
    .monitorMode(monitorMode), .supplyMode(supplyMode), .rcClkPin(rcClkPin),
    .pinsToXtal(pinsToXtal), .xtalEnable(xtalEnable), .slowClkXtal(slowClkXtal),
    .rcEnable(rcEnable)
  );

  // 10 MHz clock and a slower rc oscillator pin
  always #50 clk = ~clk;
  always @(posedge clk) rcCnt <= rcCnt + 2'h1;
  assign rcClkPin = rcCnt[1];

  // compare one value, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask

  // one classic wishbone cycle, waits for ack or err
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDatI <= d; wbSel <= s;
    do begin
      @(posedge clk);
      k++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && k < 20);
    rd = wbDatO;
    er = wbErr;
    if (k >= 20) chk(32'h1, 32'h0, "bus timeout");
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
  endtask

  function automatic logic [31:0] osc();
    return {28'h0, pinsToXtal, xtalEnable, slowClkXtal, rcEnable};
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog
  initial begin
    #500000;
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = 8'h00;
    wbDatI = 32'h0; wbSel = 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk(osc(), 32'h1, "osc reset");
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat, rows[i].sel);
      chk(rd & rows[i].msk, rows[i].exp, "table data");
      chk({31'h0, er}, {31'h0, rows[i].err}, "table err");
    end
    chk(monitorMode, 32'h0000370F, "monitor port");
    chk(supplyMode, 32'h00E05678, "mode port");
    wb(1'b1, 8'h18, 32'h5AA5C33C, 4'hF);
    wb(1'b0, 8'h18, 32'h0, 4'hF);
    chk(rd, 32'h5AA5C33C, "mode full write");
    $display("test table done");
    // bad key, no key lane, bit 3 clear: nothing moves; bit 2 kept zero
    wb(1'b1, 8'h10, 32'h5A000008, 4'hF);
    wb(1'b1, 8'h10, 32'hA5000008, 4'h1);
    wb(1'b1, 8'h10, 32'hA5000000, 4'hF);
    repeat (40) @(posedge clk);
    chk(osc(), 32'h1, "discarded command");
    $display("test key done");
    wb(1'b1, 8'h10, 32'hA5000008, 4'hF);
    n = 0;
    while (pinsToXtal !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    chk(osc(), 32'h9, "pins first");
    n = 0;
    while (slowClkXtal !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    chk(osc(), 32'hF, "switch before rc off");
    chk({31'h0, n > 6}, 32'h1, "startup wait");
    @(posedge clk);
    chk(osc(), 32'hE, "rc off");
    wb(1'b0, 8'h24, 32'h0, 4'hF);
    chk(rd & 32'h80, 32'h80, "status on crystal");
    $display("test switch done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk(osc(), 32'h1, "osc second reset");
    wb(1'b0, 8'h18, 32'h0, 4'hF);
    chk(rd, 32'h00E05A00, "mode second reset");
    $display("test reset done");
    report_and_stop;
  end
endmodule // supply_ctrl_register_bank_test
